//--- hdl/tcc_pkg.sv
// Constants shared by the telemetry commutator and its helpers.
// Assumes a 100 MHz system clock; levels are coded in tenths of a volt of magnitude.
package tcc_pkg;
   localparam int LVL_W = 8;
   localparam int CH_W = 7;
   localparam int NUM_CH = 120;
   localparam int GRP_W = 3;
   // Slot indices
   localparam logic [6:0] CH_START = 7'h00;
   localparam logic [6:0] CH_FIRST = 7'h01;
   localparam logic [6:0] CH_LAST = 7'h78;
   localparam logic [6:0] CH_FRAME = 7'h79;
   localparam logic [6:0] CH_MARK_STEP = 7'h0A;
   localparam logic [6:0] CH_CAL1 = 7'h01;
   localparam logic [6:0] CH_CAL2 = 7'h02;
   localparam logic [6:0] CH_CAL3 = 7'h03;
   localparam logic [6:0] CH_CAL4 = 7'h04;
   localparam logic [6:0] CH_AGC1 = 7'h07;
   localparam logic [6:0] CH_AGC2 = 7'h08;
   localparam logic [6:0] CH_HALF = 7'h6A;
   // Diode-merged channels 78, 82, 94..97, 104
   localparam logic [6:0] CH_OR_A = 7'h4E;
   localparam logic [6:0] CH_OR_B = 7'h52;
   localparam logic [6:0] CH_OR_LO = 7'h5E;
   localparam logic [6:0] CH_OR_HI = 7'h61;
   localparam logic [6:0] CH_OR_C = 7'h68;
   // Four-level channels 9, 44, 53, 55, 105, 108
   localparam logic [6:0] CH_FOUR0 = 7'h09;
   localparam logic [6:0] CH_FOUR1 = 7'h2C;
   localparam logic [6:0] CH_FOUR2 = 7'h35;
   localparam logic [6:0] CH_FOUR3 = 7'h37;
   localparam logic [6:0] CH_FOUR4 = 7'h69;
   localparam logic [6:0] CH_FOUR5 = 7'h6C;
   localparam int NUM_FOUR = 6;
   // Gate groups
   localparam int GATES_PER_GRP = 16;
   localparam logic [2:0] GRP_FIRST = 3'h0;
   localparam logic [2:0] GRP_LAST = 3'h7;
   // Level codes
   localparam logic [7:0] LVL_ZERO = 8'h00;
   localparam logic [7:0] LVL_CAL1 = 8'h05;
   localparam logic [7:0] LVL_CAL2 = 8'h0F;
   localparam logic [7:0] LVL_CAL3 = 8'h23;
   localparam logic [7:0] LVL_CAL4 = 8'h2D;
   localparam logic [7:0] LVL_MARK = 8'h32;
   localparam logic [7:0] LVL_FOUR_A = 8'h09;
   localparam logic [7:0] LVL_FOUR_B = 8'h12;
   localparam logic [7:0] LVL_MAX = 8'hFF;
   localparam logic [7:0] AGC_GAIN = 8'h02;
   // Start hold timing
   localparam int CLK_MHZ = 100;
   localparam int HOLD_MS = 1200;
   localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
   localparam int HOLD_W = 27;
endpackage

//--- hdl/tcc_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ns
module tcc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else if (ce_i) begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // tcc_sync

//--- hdl/tcc_level_mux.sv
// Selects and conditions the level for one slot.
// Assumes inputs are already synchronised; purely combinational.
`timescale 1ns/1ns
module tcc_level_mux #(
   parameter bit SECOND_UNIT = 1'b0
) (
   // Slot
   input wire logic [6:0] chan_i,
   // Sources
   input wire logic [tcc_pkg::NUM_CH*tcc_pkg::LVL_W-1:0] ext_a_i,
   input wire logic [tcc_pkg::NUM_CH*tcc_pkg::LVL_W-1:0] ext_b_i,
   input wire logic [tcc_pkg::NUM_FOUR-1:0] two_a_i,
   input wire logic [tcc_pkg::NUM_FOUR-1:0] two_b_i,
   // Result
   output logic [7:0] level_o
);
   logic [2:0] four_idx;
   logic is_four;
   wire [6:0] idx = chan_i - tcc_pkg::CH_FIRST;
   wire [9:0] base = {3'h0, idx} * 10'(tcc_pkg::LVL_W);
   wire in_range = chan_i >= tcc_pkg::CH_FIRST && chan_i <= tcc_pkg::CH_LAST;
   wire [7:0] src_a = in_range ? ext_a_i[base +: tcc_pkg::LVL_W] : tcc_pkg::LVL_ZERO;
   wire [7:0] src_b = in_range ? ext_b_i[base +: tcc_pkg::LVL_W] : tcc_pkg::LVL_ZERO;
   wire [7:0] merged = src_a | src_b;
   wire [15:0] agc_prod = src_a * tcc_pkg::AGC_GAIN;
   wire [7:0] agc_lvl = (agc_prod > {8'h00, tcc_pkg::LVL_MAX}) ? tcc_pkg::LVL_MAX
                                                              : agc_prod[7:0];
   wire [7:0] four_lvl = (two_a_i[four_idx] ? tcc_pkg::LVL_FOUR_A : tcc_pkg::LVL_ZERO)
                       + (two_b_i[four_idx] ? tcc_pkg::LVL_FOUR_B : tcc_pkg::LVL_ZERO);
   wire is_mark = chan_i >= tcc_pkg::CH_MARK_STEP && chan_i <= tcc_pkg::CH_LAST
                  && (chan_i % tcc_pkg::CH_MARK_STEP) == 7'h00;
   wire is_or = chan_i == tcc_pkg::CH_OR_A || chan_i == tcc_pkg::CH_OR_B
                || chan_i == tcc_pkg::CH_OR_C
                || (chan_i >= tcc_pkg::CH_OR_LO && chan_i <= tcc_pkg::CH_OR_HI);
   // Second unit swaps the two middle calibration levels
   wire [7:0] lvl_ch2 = SECOND_UNIT ? tcc_pkg::LVL_CAL3 : tcc_pkg::LVL_CAL2;
   wire [7:0] lvl_ch3 = SECOND_UNIT ? tcc_pkg::LVL_CAL2 : tcc_pkg::LVL_CAL3;

   always_comb begin
      is_four = 1'b1;
      case (chan_i)
         tcc_pkg::CH_FOUR0: four_idx = 3'h0;
         tcc_pkg::CH_FOUR1: four_idx = 3'h1;
         tcc_pkg::CH_FOUR2: four_idx = 3'h2;
         tcc_pkg::CH_FOUR3: four_idx = 3'h3;
         tcc_pkg::CH_FOUR4: four_idx = 3'h4;
         tcc_pkg::CH_FOUR5: four_idx = 3'h5;
         default: begin
            four_idx = 3'h0;
            is_four = 1'b0;
         end
      endcase
   end

   always_comb begin
      if (!in_range) begin
         level_o = tcc_pkg::LVL_ZERO; // ground gate in frame slot
      end else if (chan_i == tcc_pkg::CH_CAL1) begin
         level_o = tcc_pkg::LVL_CAL1;
      end else if (chan_i == tcc_pkg::CH_CAL2) begin
         level_o = lvl_ch2;
      end else if (chan_i == tcc_pkg::CH_CAL3) begin
         level_o = lvl_ch3;
      end else if (chan_i == tcc_pkg::CH_CAL4) begin
         level_o = tcc_pkg::LVL_CAL4;
      end else if (is_mark) begin
         level_o = tcc_pkg::LVL_MARK;
      end else if (chan_i == tcc_pkg::CH_AGC1 || chan_i == tcc_pkg::CH_AGC2) begin
         level_o = agc_lvl;
      end else if (is_four) begin
         level_o = four_lvl;
      end else if (is_or) begin
         level_o = merged;
      end else if (chan_i == tcc_pkg::CH_HALF) begin
         level_o = merged >> 1;
      end else begin
         level_o = src_a;
      end
   end
endmodule // tcc_level_mux

//--- hdl/tcc_commutator.sv
// Telemetry channel commutator: start hold, park, 121-slot stepped frame.
// Assumes step and power come from the power distribution controller as slow
// pins; telemetry inputs are slow levels from outside this clock domain.
// How it works
// RULE1: fixed channel order, one step per received clock pulse, equal slots.
// RULE2: on power-up hold the start position for 1.2 seconds.
// RULE3: then sit on channel 1 until clock pulses arrive.
// RULE4: a frame walks 120 telemetry channels, one per slot.
// RULE5: eight gate groups; first has 16 gates plus the start gate.
// RULE6: groups two to seven each cover the next 16 channels.
// RULE7: group eight has 8 gates plus a ground gate giving zero in frame slot.
// RULE8: frame pulse asserted only during slot 121.
// RULE9: controller removes power on seeing the frame pulse.
// RULE10: marker level on channel 10 and every tenth up to 120.
// RULE11: channels 1 to 4 carry internal calibration levels.
// RULE12: second unit swaps the calibration levels of channels 2 and 3.
// RULE13: each unit has own power input; only a powered unit outputs samples.
// RULE14: channels 7 and 8 carry conditioned receiver gain-control levels.
// RULE15: channels 78, 82, 94-97, 104 OR two exclusive lines.
// RULE16: channels 9, 44, 53, 55, 105, 108 combine two bits into four levels.
// RULE17: channel 106 gives half the active three-level input.
// RULE18: all other channels pass their external input directly.
// RULE19: each slot reports channel index and level; start shows as index 0.
`timescale 1ns/1ns
module tcc_commutator #(
   parameter bit SECOND_UNIT = 1'b0,
   parameter int HOLD_CYCLES = tcc_pkg::HOLD_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // From power distribution controller
   input wire logic power_i,
   input wire logic step_i,
   // Telemetry sources
   input wire logic [tcc_pkg::NUM_CH*tcc_pkg::LVL_W-1:0] ext_a_i,
   input wire logic [tcc_pkg::NUM_CH*tcc_pkg::LVL_W-1:0] ext_b_i,
   input wire logic [tcc_pkg::NUM_FOUR-1:0] two_a_i,
   input wire logic [tcc_pkg::NUM_FOUR-1:0] two_b_i,
   // Sample stream
   output logic active_o,
   output logic [6:0] chan_o,
   output logic [7:0] level_o,
   output logic [2:0] group_o,
   output logic start_gate_o,
   output logic frame_pulse_o
);
   typedef enum logic [1:0] {
      ST_OFF,
      ST_HOLD,
      ST_PARK,
      ST_RUN
   } tcc_state_t;

   localparam logic [26:0] HOLD_LAST = 27'(HOLD_CYCLES - 1);
   localparam int SYNC_W = 2 * tcc_pkg::NUM_CH * tcc_pkg::LVL_W + 2 * tcc_pkg::NUM_FOUR + 2;

   tcc_state_t state;
   tcc_state_t next_state;
   logic [26:0] hold_cnt;
   logic step_q;
   logic [6:0] chan;
   logic [6:0] next_chan;
   logic [SYNC_W-1:0] sync_q;
   logic [7:0] mux_level;
   logic [7:0] slot_cnt;

   // Controller keeps step high and low at least 2 clocks each: 4-clock slots at least
   localparam logic [7:0] SLOT_MIN_CNT = 8'h03;
   localparam logic [7:0] SLOT_CNT_MAX = 8'hFF;

   // Power, step and telemetry pins pass two flops before use; ce_i and rst_i do not
   tcc_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({power_i, step_i, two_b_i, two_a_i, ext_b_i, ext_a_i}),
      .q_o(sync_q)
   );

   localparam int EXT_W = tcc_pkg::NUM_CH * tcc_pkg::LVL_W;
   wire [EXT_W-1:0] ext_a_s = sync_q[EXT_W-1:0];
   wire [EXT_W-1:0] ext_b_s = sync_q[2*EXT_W-1:EXT_W];
   wire [5:0] two_a_s = sync_q[2*EXT_W +: tcc_pkg::NUM_FOUR];
   wire [5:0] two_b_s = sync_q[2*EXT_W+tcc_pkg::NUM_FOUR +: tcc_pkg::NUM_FOUR];
   wire step_s = sync_q[SYNC_W-2];
   wire power_s = sync_q[SYNC_W-1];
   wire step_pulse = step_s & ~step_q;
   wire hold_done = hold_cnt == HOLD_LAST;
   wire at_frame = chan == tcc_pkg::CH_FRAME;
   wire [6:0] chan_inc = at_frame ? tcc_pkg::CH_FIRST : chan + tcc_pkg::CH_FIRST;
   // Group of a slot: 16 channels per group; frame slot falls in the last group
   wire [6:0] grp_pos = next_chan - tcc_pkg::CH_FIRST;
   wire [2:0] next_group = (next_chan == tcc_pkg::CH_FRAME) ? tcc_pkg::GRP_LAST
                         : (next_chan == tcc_pkg::CH_START) ? tcc_pkg::GRP_FIRST
                         : 3'(grp_pos / 7'(tcc_pkg::GATES_PER_GRP));

   always_comb begin
      next_state = state;
      next_chan = chan;
      case (state)
         ST_OFF: begin
            next_chan = tcc_pkg::CH_START;
            if (power_s) begin
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            next_chan = tcc_pkg::CH_START;
            if (hold_done) begin // RULE2
               next_state = ST_PARK;
               next_chan = tcc_pkg::CH_FIRST; // RULE3
            end
         end
         ST_PARK: begin
            if (step_pulse) begin // RULE3
               next_state = ST_RUN;
               next_chan = chan_inc;
            end
         end
         ST_RUN: begin
            if (step_pulse) begin
               next_chan = chan_inc; // RULE1 RULE4
            end
         end
         default: begin
            next_state = ST_OFF;
            next_chan = tcc_pkg::CH_START;
         end
      endcase
      if (!power_s) begin // RULE13
         next_state = ST_OFF;
         next_chan = tcc_pkg::CH_START;
      end
   end

   // RULE7 RULE10 RULE11 RULE12 RULE14 RULE15 RULE16 RULE17 RULE18
   tcc_level_mux #(
      .SECOND_UNIT(SECOND_UNIT)
   ) u_mux (
      .chan_i(next_chan),
      .ext_a_i(ext_a_s),
      .ext_b_i(ext_b_s),
      .two_a_i(two_a_s),
      .two_b_i(two_b_s),
      .level_o(mux_level)
   );

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_OFF;
         chan <= tcc_pkg::CH_START;
         step_q <= 1'b0;
      end else if (ce_i) begin
         state <= next_state;
         chan <= next_chan;
         step_q <= step_s;
      end
   end

   // Hold timer restarts each time the unit leaves OFF
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hold_cnt <= '0;
      end else if (ce_i) begin
         hold_cnt <= (state == ST_HOLD && !hold_done) ? hold_cnt + 27'h1 : '0; // RULE2
      end
   end

   // Outputs registered together so index and level stay aligned
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         active_o <= 1'b0;
         chan_o <= tcc_pkg::CH_START;
         level_o <= tcc_pkg::LVL_ZERO;
         group_o <= tcc_pkg::GRP_FIRST;
         start_gate_o <= 1'b0;
         frame_pulse_o <= 1'b0;
      end else if (ce_i) begin
         active_o <= next_state != ST_OFF; // RULE13
         chan_o <= next_chan; // RULE19
         level_o <= (next_state == ST_OFF || next_state == ST_HOLD) ? tcc_pkg::LVL_ZERO
                                                                    : mux_level;
         group_o <= next_group; // RULE5 RULE6 RULE7
         start_gate_o <= next_state == ST_HOLD; // RULE5
         frame_pulse_o <= next_chan == tcc_pkg::CH_FRAME; // RULE8
      end
   end

   // Checker helper: clocks spent in the current slot, saturating
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         slot_cnt <= '0;
      end else if (ce_i) begin
         slot_cnt <= (next_chan != chan) ? '0
                   : (slot_cnt == SLOT_CNT_MAX) ? slot_cnt : slot_cnt + 8'h01;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   frame_slot_a: assert property (frame_pulse_o |-> chan_o == tcc_pkg::CH_FRAME && active_o) // RULE8
      else $error("frame pulse outside slot 121");
   frame_zero_a: assert property (frame_pulse_o |-> level_o == tcc_pkg::LVL_ZERO) // RULE7
      else $error("frame slot level not zero");
   marker_level_a: assert property ((active_o && chan_o >= tcc_pkg::CH_MARK_STEP // RULE10
         && chan_o <= tcc_pkg::CH_LAST && (chan_o % tcc_pkg::CH_MARK_STEP) == 7'h00)
         |-> level_o == tcc_pkg::LVL_MARK)
      else $error("marker slot lacks marker level");
   cal_swap_a: assert property ((active_o && !start_gate_o && chan_o == tcc_pkg::CH_CAL2) // RULE12
         |-> level_o == (SECOND_UNIT ? tcc_pkg::LVL_CAL3 : tcc_pkg::LVL_CAL2))
      else $error("channel 2 calibration wrong for this unit");
   cal_fixed_a: assert property ((active_o && chan_o == tcc_pkg::CH_CAL4) // RULE11
         |-> level_o == tcc_pkg::LVL_CAL4)
      else $error("channel 4 calibration wrong");
   step_adv_a: assert property ((ce_i && power_s && state == ST_RUN && step_pulse && !at_frame) // RULE1
         |=> chan_o == $past(chan) + tcc_pkg::CH_FIRST)
      else $error("step did not advance one channel");
   no_step_a: assert property ((ce_i && power_s && state == ST_RUN && !step_pulse) // RULE4
         |=> chan_o == $past(chan))
      else $error("channel moved without a step");
   park_hold_a: assert property ((state == ST_PARK && ce_i && power_s && !step_pulse) // RULE3
         |=> chan_o == tcc_pkg::CH_FIRST && !start_gate_o)
      else $error("park did not stay on channel 1");
   hold_len_a: assert property ((state == ST_HOLD) |-> hold_cnt <= HOLD_LAST // RULE2
         && chan == tcc_pkg::CH_START)
      else $error("start hold exceeded or left start position");
   hold_exit_a: assert property ((state == ST_HOLD && ce_i && power_s && hold_done) // RULE2
         |=> state == ST_PARK)
      else $error("start hold did not end on time");
   power_off_a: assert property ((ce_i && !power_s) |=> !active_o && chan_o == tcc_pkg::CH_START) // RULE13
      else $error("unpowered unit still active");
   group_map_a: assert property ((active_o && chan_o >= tcc_pkg::CH_FIRST // RULE6
         && chan_o <= tcc_pkg::CH_LAST) |-> group_o == 3'((chan_o - 7'h01) >> 4))
      else $error("gate group mismatch");

   start_gate_a: assert property (start_gate_o |-> chan_o == tcc_pkg::CH_START // RULE5
         && active_o && level_o == tcc_pkg::LVL_ZERO && group_o == tcc_pkg::GRP_FIRST)
      else $error("start gate slot wrong");

   frame_group_a: assert property (frame_pulse_o |-> group_o == tcc_pkg::GRP_LAST) // RULE7
      else $error("frame slot not in last group");

   chan_range_a: assert property (chan_o <= tcc_pkg::CH_FRAME) // RULE4
      else $error("slot index beyond frame slot");

   off_quiet_a: assert property (!active_o |-> level_o == tcc_pkg::LVL_ZERO // RULE13
         && !frame_pulse_o && !start_gate_o)
      else $error("idle unit drives the stream");

   cal_one_a: assert property ((active_o && !start_gate_o && chan_o == tcc_pkg::CH_CAL1) // RULE11
         |-> level_o == tcc_pkg::LVL_CAL1)
      else $error("channel 1 calibration wrong");

   cal_three_a: assert property ((active_o && chan_o == tcc_pkg::CH_CAL3) // RULE12
         |-> level_o == (SECOND_UNIT ? tcc_pkg::LVL_CAL2 : tcc_pkg::LVL_CAL3))
      else $error("channel 3 calibration wrong for this unit");

   agc_even_a: assert property ((active_o && (chan_o == tcc_pkg::CH_AGC1 // RULE14
         || chan_o == tcc_pkg::CH_AGC2)) |-> !level_o[0] || level_o == tcc_pkg::LVL_MAX)
      else $error("gain-control level not doubled");

   wrap_a: assert property ((ce_i && power_s && state == ST_RUN && step_pulse && at_frame) // RULE4
         |=> chan_o == tcc_pkg::CH_FIRST && !frame_pulse_o)
      else $error("frame slot did not wrap to channel 1");

   park_exit_a: assert property ((state == ST_PARK && ce_i && power_s && step_pulse) // RULE3
         |=> state == ST_RUN && chan_o == tcc_pkg::CH_FIRST + tcc_pkg::CH_FIRST)
      else $error("first step from park wrong");

   hold_entry_a: assert property ((state == ST_OFF && ce_i && power_s) // RULE2
         |=> state == ST_HOLD && start_gate_o && chan_o == tcc_pkg::CH_START)
      else $error("power-up did not enter start hold");

   run_chan_a: assert property ((state == ST_RUN) |-> chan != tcc_pkg::CH_START) // RULE3
      else $error("running unit back on start position");

   ce_freeze_a: assert property (!ce_i |=> $stable(chan_o) && $stable(level_o) // RULE1
         && $stable(active_o) && $stable(hold_cnt))
      else $error("state moved while clock enable low");

   slot_min_a: assert property ((ce_i && power_s && state == ST_RUN && next_chan != chan) // RULE1
         |-> slot_cnt >= SLOT_MIN_CNT)
      else $error("slot shorter than step spacing allows");

   hold_seen_c: cover property (state == ST_HOLD ##1 state == ST_PARK);
   first_step_c: cover property (state == ST_PARK ##1 state == ST_RUN);
   frame_seen_c: cover property (frame_pulse_o);
   wrap_seen_c: cover property (frame_pulse_o ##[1:8] chan_o == tcc_pkg::CH_FIRST);
   cut_seen_c: cover property (active_o ##1 !active_o);
endmodule // tcc_commutator

//--- test/tcc_pdc_model.sv
// Behavioural power distribution controller facing one commutator.
// Assumes the bench asks for power and stepping; steps are 3 clocks high, 3 low.
`timescale 1ns/1ns
module tcc_pdc_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Requests from the bench
   input wire logic pwr_cmd_i,
   input wire logic run_i,
   input wire logic cut_en_i,
   // From the commutator
   input wire logic frame_pulse_i,
   // To the commutator
   output logic power_o,
   output logic step_o
);
   logic cut;
   logic [2:0] ph;

   // Cut latch cleared only by dropping the request, so power stays off
   assign power_o = pwr_cmd_i & ~cut;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cut <= 1'b0;
         ph <= 3'h0;
         step_o <= 1'b0;
      end else begin
         if (!pwr_cmd_i) begin
            cut <= 1'b0;
         end else if (cut_en_i && frame_pulse_i) begin
            cut <= 1'b1;
         end
         // Phase restarts with each run so its first pulse is not clipped short
         ph <= !run_i ? 3'h0 : (ph == 3'h5) ? 3'h0 : ph + 3'h1;
         step_o <= run_i && (ph < 3'h3);
      end
   end
endmodule // tcc_pdc_model

//--- test/telemetry_channel_commutator_bench.sv
// Self-checking bench: two commutator units sharing the controller's step line.
// Assumes a 100 MHz clock and a start hold shortened to HOLD cycles.
`timescale 1ns/1ns
`define TCC_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module telemetry_channel_commutator_bench;
   localparam int HOLD = 20;
   logic clk_i, rst_i, pwr_cmd, run, cut_en, pwr2, power, step, ce;
   logic [tcc_pkg::NUM_CH*tcc_pkg::LVL_W-1:0] ext_a, ext_b;
   logic [tcc_pkg::NUM_FOUR-1:0] two_a, two_b;
   logic active, start_gate, frame_pulse, act2;
   logic [6:0] chan, ch2;
   logic [7:0] level, lv2;
   logic [2:0] group;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;

   tcc_pdc_model u_pdc (.clk_i(clk_i), .rst_i(rst_i), .pwr_cmd_i(pwr_cmd), .run_i(run),
      .cut_en_i(cut_en), .frame_pulse_i(frame_pulse), .power_o(power), .step_o(step));
   tcc_commutator #(.SECOND_UNIT(1'b0), .HOLD_CYCLES(HOLD)) u_dut (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(ce), .power_i(power), .step_i(step), .ext_a_i(ext_a),
      .ext_b_i(ext_b), .two_a_i(two_a), .two_b_i(two_b), .active_o(active), .chan_o(chan),
      .level_o(level), .group_o(group), .start_gate_o(start_gate),
      .frame_pulse_o(frame_pulse));
   tcc_commutator #(.SECOND_UNIT(1'b1), .HOLD_CYCLES(HOLD)) u_dut2 (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(ce), .power_i(pwr2), .step_i(step), .ext_a_i(ext_a),
      .ext_b_i(ext_b), .two_a_i(two_a), .two_b_i(two_b), .active_o(act2), .chan_o(ch2),
      .level_o(lv2), .group_o(), .start_gate_o(), .frame_pulse_o());

   function automatic logic [7:0] exp_lvl(input int n, input bit u2);
      int four_ch[6] = '{9, 44, 53, 55, 105, 108};
      int or_ch[7] = '{78, 82, 94, 95, 96, 97, 104};
      logic [7:0] a;
      a = 8'h80 | 8'(n);
      if (n == 121) return tcc_pkg::LVL_ZERO;
      if (n % 10 == 0) return tcc_pkg::LVL_MARK;
      if (n == 1) return tcc_pkg::LVL_CAL1;
      if (n == 2) return u2 ? tcc_pkg::LVL_CAL3 : tcc_pkg::LVL_CAL2;
      if (n == 3) return u2 ? tcc_pkg::LVL_CAL2 : tcc_pkg::LVL_CAL3;
      if (n == 4) return tcc_pkg::LVL_CAL4;
      if (n == 7 || n == 8) return (a > 8'h7F) ? tcc_pkg::LVL_MAX : {a[6:0], 1'b0};
      if (n == 106) return {1'b0, a[7:2], 1'b1};
      for (int i = 0; i < 6; i++) if (n == four_ch[i]) return 8'(9 * two_a[i] + 18 * two_b[i]);
      for (int i = 0; i < 7; i++) if (n == or_ch[i]) return a | 8'h03;
      return a;
   endfunction

   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask

   task automatic print_verdict();
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic t_power_up();
      int i;
      pwr_cmd = 1'b1;
      for (i = 0; i < 10 && active !== 1'b1; i++) tick();
      `TCC_CHK("start gate", 1'b1, start_gate)
      `TCC_CHK("start chan", 7'h00, chan)
      `TCC_CHK("hold level", 8'h00, level)
      // Frozen hold timer stretches the hold by exactly the frozen clocks
      ce = 1'b0;
      repeat (10) tick();
      `TCC_CHK("frozen gate", 1'b1, start_gate)
      `TCC_CHK("frozen chan", 7'h00, chan)
      ce = 1'b1;
      for (i = 0; i < 3 * HOLD && chan !== 7'h01; i++) tick();
      `TCC_CHK("hold len", 1'b1, i >= HOLD && i <= HOLD + 1)
      `TCC_CHK("start gate off", 1'b0, start_gate)
   endtask

   task automatic t_park();
      repeat (30) tick();
      `TCC_CHK("park chan", 7'h01, chan)
      `TCC_CHK("park level", tcc_pkg::LVL_CAL1, level)
      `TCC_CHK("park group", 3'h0, group)
   endtask

   task automatic t_frame_walk();
      int len;
      logic [6:0] last;
      cut_en = 1'b1;
      run = 1'b1;
      for (int n = 2; n <= 121; n++) begin
         last = chan;
         len = 0;
         do begin
            tick();
            len++;
         end while (chan === last && len < 20);
         `TCC_CHK("chan", 7'(n), chan)
         if (n > 2) `TCC_CHK("slot len", 6, len)
         `TCC_CHK("level", exp_lvl(n, 1'b0), level)
         `TCC_CHK("group", (n == 121) ? 3'h7 : 3'((n - 1) / 16), group)
         `TCC_CHK("frame", n == 121, frame_pulse)
         `TCC_CHK("idle unit", 1'b0, act2)
      end
      for (int i = 0; i < 10 && active !== 1'b0; i++) tick();
      `TCC_CHK("cut active", 1'b0, active)
      `TCC_CHK("cut level", 8'h00, level)
      `TCC_CHK("cut frame", 1'b0, frame_pulse)
      run = 1'b0;
      pwr_cmd = 1'b0;
      cut_en = 1'b0;
   endtask

   task automatic t_second_unit();
      int i;
      pwr2 = 1'b1;
      for (i = 0; i < 80 && ch2 !== 7'h01; i++) tick();
      `TCC_CHK("u2 active", 1'b1, act2)
      `TCC_CHK("u2 park", tcc_pkg::LVL_CAL1, lv2)
      `TCC_CHK("u1 idle", 1'b0, active)
      run = 1'b1;
      for (int n = 2; n <= 3; n++) begin
         for (i = 0; i < 20 && ch2 !== 7'(n); i++) tick();
         `TCC_CHK("u2 chan", 7'(n), ch2)
         `TCC_CHK("u2 cal", exp_lvl(n, 1'b1), lv2)
      end
      run = 1'b0;
      pwr2 = 1'b0;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         num_errors++;
         print_verdict();
      end
   end

   initial begin
      rst_i = 1'b1;
      ce = 1'b1;
      pwr_cmd = 1'b0;
      run = 1'b0;
      cut_en = 1'b0;
      pwr2 = 1'b0;
      ext_b = {120{8'h03}};
      two_a = 6'h15;
      two_b = 6'h33;
      for (int n = 1; n <= 120; n++) ext_a[(n - 1) * 8 +: 8] = 8'h80 | 8'(n);
      repeat (16) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      t_power_up();
      t_park();
      t_frame_walk();
      t_second_unit();
      print_verdict();
   end
endmodule // telemetry_channel_commutator_bench
